// File: cgc_regs.svh
`ifndef CGC_REGS_SVH
`define CGC_REGS_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define CGC_OFS_CONTROL     5'h04
`define CGC_OFS_DIVIDER     5'h08
`define CGC_OFS_KEEP        5'h0c
`define CGC_OFS_STATUS      5'h10

// ****************************************************************
// Field positions.
// ****************************************************************
`define CGC_SEL_MSB         3
`define CGC_SEL_LSB         0
`define CGC_SOURCE_MSB      12
`define CGC_SOURCE_LSB      8
`define CGC_BIT_GEN_ON      16
`define CGC_BIT_BALANCE     17
`define CGC_BIT_OUT_OFF     18
`define CGC_BIT_OUT_EN      19
`define CGC_BIT_DIV_MODE    20
`define CGC_BIT_RUN_STDBY   21
`define CGC_FACTOR_MSB      23
`define CGC_FACTOR_LSB      8

// ****************************************************************
// Reset values and sizes.
// ****************************************************************
`define CGC_CTRL_RST_G0     32'h00010600
`define CGC_CTRL_RST_G2     32'h00010302
`define CGC_FACTOR_RST      16'h0000
`define CGC_NUM_GEN         9
`define CGC_FACTOR_W        16
`define CGC_FACTOR_W_G0     8
`define CGC_FACTOR_W_G1     16
`define CGC_FACTOR_W_G2     5
`define CGC_FACTOR_W_OTHER  8
`define CGC_NUM_SOURCES     9
`define CGC_MAX_EXP         31

`endif

// File: cgc_pkg.sv
`include "cgc_regs.svh"

package cgc_pkg;

    // ************************************************************
    // Types.
    // ************************************************************
    typedef enum logic [4:0] {
        CGC_SOURCE_CRYSTAL_OSC      = 5'h00,
        CGC_SOURCE_GEN_INPUT_PAD    = 5'h01,
        CGC_SOURCE_GENERATOR_ONE    = 5'h02,
        CGC_SOURCE_ULP_32K_OSC      = 5'h03,
        CGC_SOURCE_INTERNAL_32K_OSC = 5'h04,
        CGC_SOURCE_CRYSTAL_32K_OSC  = 5'h05,
        CGC_SOURCE_INTERNAL_8MHZ    = 5'h06,
        CGC_SOURCE_FLL_48           = 5'h07,
        CGC_SOURCE_FRAC_PLL_96      = 5'h08
    } cgc_source_e;

    typedef struct packed {
        logic       run_standby;
        logic       divide_mode;
        logic       out_en;
        logic       out_off_val;
        logic       duty_balance;
        logic       gen_on;
        logic [4:0] source_select;
    } cgc_ctrl_s;

    typedef logic [`CGC_FACTOR_W-1:0] cgc_factor_t;

    // ************************************************************
    // Functions.
    // ************************************************************
    function automatic cgc_ctrl_s cgc_ctrl_unpack(input logic [31:0] w);
        cgc_ctrl_s c;
        c.run_standby   = w[`CGC_BIT_RUN_STDBY];
        c.divide_mode   = w[`CGC_BIT_DIV_MODE];
        c.out_en        = w[`CGC_BIT_OUT_EN];
        c.out_off_val   = w[`CGC_BIT_OUT_OFF];
        c.duty_balance  = w[`CGC_BIT_BALANCE];
        c.gen_on        = w[`CGC_BIT_GEN_ON];
        c.source_select = w[`CGC_SOURCE_MSB:`CGC_SOURCE_LSB];
        return c;
    endfunction

    function automatic logic [31:0] cgc_ctrl_pack(input cgc_ctrl_s c,
                                                  input logic [3:0] sel);
        logic [31:0] w;
        w                                   = 32'h00000000;
        w[`CGC_BIT_RUN_STDBY]               = c.run_standby;
        w[`CGC_BIT_DIV_MODE]                = c.divide_mode;
        w[`CGC_BIT_OUT_EN]                  = c.out_en;
        w[`CGC_BIT_OUT_OFF]                 = c.out_off_val;
        w[`CGC_BIT_BALANCE]                 = c.duty_balance;
        w[`CGC_BIT_GEN_ON]                  = c.gen_on;
        w[`CGC_SOURCE_MSB:`CGC_SOURCE_LSB]  = c.source_select;
        w[`CGC_SEL_MSB:`CGC_SEL_LSB]        = sel;
        return w;
    endfunction

    function automatic cgc_ctrl_s cgc_ctrl_reset(input int g);
        logic [31:0] w;
        if (g == 0) begin
            w = `CGC_CTRL_RST_G0;
        end else if (g == 2) begin
            w = `CGC_CTRL_RST_G2;
        end else begin
            w = 32'h00000000;
        end
        return cgc_ctrl_unpack(w);
    endfunction

    function automatic cgc_factor_t cgc_factor_mask(input int g);
        int width;
        if (g == 0) begin
            width = `CGC_FACTOR_W_G0;
        end else if (g == 1) begin
            width = `CGC_FACTOR_W_G1;
        end else if (g == 2) begin
            width = `CGC_FACTOR_W_G2;
        end else begin
            width = `CGC_FACTOR_W_OTHER;
        end
        return cgc_factor_t'((32'h1 << width) - 32'h1);
    endfunction

endpackage

// File: cgc_if.sv
`timescale 1ns/10ps

// ****************************************************************
// Register access between bus slave and register core.
// ****************************************************************
interface cgc_reg_if;
    logic        wr_stb;
    logic [4:0]  addr;
    logic [31:0] wdata;
    logic [3:0]  be;
    logic [31:0] rdata;
    modport slave (output wr_stb, output addr, output wdata,
                   output be, input rdata);
    modport core  (input wr_stb, input addr, input wdata,
                   input be, output rdata);
endinterface

// ****************************************************************
// Settings of one generator towards its divider.
// ****************************************************************
interface cgc_cfg_if;
    logic        gen_on;
    logic        balance;
    logic        mode;
    logic [15:0] factor;
    logic        source_level;
    modport core (output gen_on, output balance, output mode,
                  output factor, output source_level);
    modport div  (input gen_on, input balance, input mode,
                  input factor, input source_level);
endinterface

// File: cgc_avalon_slave.sv
`timescale 1ns/10ps

module cgc_avalon_slave
    import cgc_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    input  wire logic [4:0]  address_i,
    input  wire logic        read_i,
    input  wire logic        write_i,
    input  wire logic [31:0] writedata_i,
    input  wire logic [3:0]  byteenable_i,
    output logic             waitrequest_o,
    output logic [31:0]      readdata_o,
    cgc_reg_if.slave         bus
);

    logic        wait_q;
    logic        wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // ************************************************************
    // One wait state, then completion.
    // ************************************************************
    always_comb begin
        wait_d  = 1'b1;
        rdata_d = rdata_q;
        if ((read_i || write_i) && wait_q) begin
            wait_d = 1'b0;
            if (read_i) begin
                rdata_d = bus.rdata;
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign bus.wr_stb     = write_i && !wait_q;
    assign bus.addr       = address_i;
    assign bus.wdata      = writedata_i;
    assign bus.be         = byteenable_i;
    assign waitrequest_o  = wait_q;
    assign readdata_o     = rdata_q;

endmodule

// File: cgc_gen_divider.sv
`timescale 1ns/10ps
`include "cgc_regs.svh"

module cgc_gen_divider
    import cgc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic resetn_i,
    cgc_cfg_if.div    cfg,
    output logic      gen_clk_o
);

    logic        prev_q;
    logic        prev_d;
    logic [32:0] cnt_q;
    logic [32:0] cnt_d;
    logic        out_q;
    logic        out_d;
    logic [32:0] period;
    logic [32:0] limit;
    logic [32:0] thresh;
    logic [16:0] expo;
    logic        rise;
    logic        fall;
    logic        step;

    // ************************************************************
    // Division period and edge counting.
    // ************************************************************
    always_comb begin
        expo   = {1'b0, cfg.factor} + 17'h00001;
        period = 33'h000000001;
        if (cfg.mode) begin
            if (expo > 17'(`CGC_MAX_EXP)) begin
                period = 33'h000000001 << `CGC_MAX_EXP;
            end else begin
                period = 33'h000000001 << expo;
            end
        end else if (cfg.factor > 16'h0001) begin
            period = {17'h00000, cfg.factor};
        end
        rise = cfg.source_level && !prev_q;
        fall = !cfg.source_level && prev_q;
        if (cfg.balance) begin
            limit  = {period[31:0], 1'b0} - 33'h000000001;
            thresh = period;
            step   = rise || fall;
        end else begin
            limit  = period - 33'h000000001;
            thresh = period >> 1;
            step   = rise;
        end
    end

    always_comb begin
        prev_d = cfg.source_level;
        cnt_d  = cnt_q;
        out_d  = out_q;
        if (!cfg.gen_on) begin
            cnt_d = 33'h000000000;
            out_d = 1'b0;
        end else if (period == 33'h000000001) begin
            cnt_d = 33'h000000000;
            out_d = cfg.source_level;
        end else begin
            if (step) begin
                if (cnt_q >= limit) begin
                    cnt_d = 33'h000000000;
                end else begin
                    cnt_d = cnt_q + 33'h000000001;
                end
            end
            out_d = (cnt_d < thresh);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            prev_q <= 1'b0;
            cnt_q  <= 33'h000000000;
            out_q  <= 1'b0;
        end else begin
            prev_q <= prev_d;
            cnt_q  <= cnt_d;
            out_q  <= out_d;
        end
    end

    assign gen_clk_o = out_q;

endmodule

// File: cgc_clock_generator_config.sv
`timescale 1ns/10ps
`include "cgc_regs.svh"

// Overview of operation
// - Duty balance bit gives 50/50 output
// - Generator on bit enables selected generator
// - Source field picks one of nine inputs
// - Control select field picks written/read generator
// - Select values nine upward address nothing
// - Power reset restores every control setting
// - User reset spares kept generators above zero
// - Power reset control values per generator
// - User reset always restores generator zero
// - Divide factor field sets selected division
// - Factor width per generator: 8,16,5,8
// - Factor bits above width ignored
// - Divider select field picks receiving generator
// - Divide mode: factor or power of two
// - Power reset clears every divider setting
module cgc_clock_generator_config
    import cgc_pkg::*;
#(
    parameter int NUM_GEN = `CGC_NUM_GEN
) (
    input  wire logic               clk_i,
    input  wire logic               resetn_i,
    input  wire logic               user_reset_i,
    input  wire logic [4:0]         avs_address_i,
    input  wire logic               avs_read_i,
    input  wire logic               avs_write_i,
    input  wire logic [31:0]        avs_writedata_i,
    input  wire logic [3:0]         avs_byteenable_i,
    output logic                    avs_waitrequest_o,
    output logic [31:0]             avs_readdata_o,
    input  wire logic               crystal_osc_i,
    input  wire logic               gen_input_pad_i,
    input  wire logic               ultra_low_power_32k_osc_i,
    input  wire logic               internal_32k_osc_i,
    input  wire logic               crystal_32k_osc_i,
    input  wire logic               internal_8mhz_osc_i,
    input  wire logic               freq_locked_loop_48_i,
    input  wire logic               frac_phase_locked_loop_96_i,
    output logic [NUM_GEN-1:0]      gen_clk_o
);

    // ************************************************************
    // Storage.
    // ************************************************************
    cgc_ctrl_s               ctrl_q [NUM_GEN];
    cgc_ctrl_s               ctrl_d [NUM_GEN];
    cgc_factor_t             factor_q [NUM_GEN];
    cgc_factor_t             factor_d [NUM_GEN];
    logic [3:0]              ctrl_rsel_q;
    logic [3:0]              ctrl_rsel_d;
    logic [3:0]              div_rsel_q;
    logic [3:0]              div_rsel_d;
    logic [NUM_GEN-1:0]      keep_q;
    logic [NUM_GEN-1:0]      keep_d;
    logic [NUM_GEN-1:0]      gen_clk;
    logic [`CGC_NUM_SOURCES-1:0] sources;

    cgc_reg_if reg_bus ();
    cgc_cfg_if cfg [NUM_GEN] ();

    // ************************************************************
    // Bus slave.
    // ************************************************************
    cgc_avalon_slave u_slave (
        .clk_i         (clk_i),
        .resetn_i      (resetn_i),
        .address_i     (avs_address_i),
        .read_i        (avs_read_i),
        .write_i       (avs_write_i),
        .writedata_i   (avs_writedata_i),
        .byteenable_i  (avs_byteenable_i),
        .waitrequest_o (avs_waitrequest_o),
        .readdata_o    (avs_readdata_o),
        .bus           (reg_bus.slave)
    );

    // ************************************************************
    // Register update.
    // ************************************************************
    always_comb begin
        logic [31:0] word;
        logic [3:0]  sel;
        cgc_factor_t fnew;
        word        = 32'h00000000;
        fnew        = `CGC_FACTOR_RST;
        sel         = reg_bus.wdata[`CGC_SEL_MSB:`CGC_SEL_LSB];
        ctrl_rsel_d = ctrl_rsel_q;
        div_rsel_d  = div_rsel_q;
        keep_d      = keep_q;
        for (int g = 0; g < NUM_GEN; g++) begin
            ctrl_d[g]   = ctrl_q[g];
            factor_d[g] = factor_q[g];
        end
        if (user_reset_i) begin
            for (int g = 0; g < NUM_GEN; g++) begin
                if (g == 0) begin
                    ctrl_d[g]   = cgc_ctrl_reset(g);
                    factor_d[g] = `CGC_FACTOR_RST;
                end else if (!keep_q[g]) begin
                    ctrl_d[g]   = cgc_ctrl_reset(g);
                    factor_d[g] = `CGC_FACTOR_RST;
                end
            end
        end else if (reg_bus.wr_stb) begin
            if (reg_bus.addr == `CGC_OFS_CONTROL) begin
                if (reg_bus.be[0]) begin
                    ctrl_rsel_d = sel;
                end
                for (int g = 0; g < NUM_GEN; g++) begin
                    if (sel == 4'(g)) begin
                        word = cgc_ctrl_pack(ctrl_q[g], sel);
                        if (reg_bus.be[1]) begin
                            word[15:8] = reg_bus.wdata[15:8];
                        end
                        if (reg_bus.be[2]) begin
                            word[23:16] = reg_bus.wdata[23:16];
                        end
                        ctrl_d[g] = cgc_ctrl_unpack(word);
                    end
                end
            end else if (reg_bus.addr == `CGC_OFS_DIVIDER) begin
                if (reg_bus.be[0]) begin
                    div_rsel_d = sel;
                end
                for (int g = 0; g < NUM_GEN; g++) begin
                    if (sel == 4'(g)) begin
                        fnew = factor_q[g];
                        if (reg_bus.be[1]) begin
                            fnew[7:0] = reg_bus.wdata[15:8];
                        end
                        if (reg_bus.be[2]) begin
                            fnew[15:8] = reg_bus.wdata[23:16];
                        end
                        factor_d[g] = fnew & cgc_factor_mask(g);
                    end
                end
            end else if (reg_bus.addr == `CGC_OFS_KEEP) begin
                for (int g = 0; g < NUM_GEN; g++) begin
                    if (reg_bus.be[g / 8]) begin
                        keep_d[g] = reg_bus.wdata[g];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (int g = 0; g < NUM_GEN; g++) begin
                ctrl_q[g]   <= cgc_ctrl_reset(g);
                factor_q[g] <= `CGC_FACTOR_RST;
            end
            ctrl_rsel_q <= 4'h0;
            div_rsel_q  <= 4'h0;
            keep_q      <= '0;
        end else begin
            for (int g = 0; g < NUM_GEN; g++) begin
                ctrl_q[g]   <= ctrl_d[g];
                factor_q[g] <= factor_d[g];
            end
            ctrl_rsel_q <= ctrl_rsel_d;
            div_rsel_q  <= div_rsel_d;
            keep_q      <= keep_d;
        end
    end

    // ************************************************************
    // Read data.
    // ************************************************************
    always_comb begin
        reg_bus.rdata = 32'h00000000;
        if (reg_bus.addr == `CGC_OFS_CONTROL) begin
            reg_bus.rdata = {28'h0000000, ctrl_rsel_q};
            for (int g = 0; g < NUM_GEN; g++) begin
                if (ctrl_rsel_q == 4'(g)) begin
                    reg_bus.rdata = cgc_ctrl_pack(ctrl_q[g], ctrl_rsel_q);
                end
            end
        end else if (reg_bus.addr == `CGC_OFS_DIVIDER) begin
            reg_bus.rdata = {28'h0000000, div_rsel_q};
            for (int g = 0; g < NUM_GEN; g++) begin
                if (div_rsel_q == 4'(g)) begin
                    reg_bus.rdata = {8'h00, factor_q[g], 4'h0, div_rsel_q};
                end
            end
        end else if (reg_bus.addr == `CGC_OFS_KEEP) begin
            reg_bus.rdata[NUM_GEN-1:0] = keep_q;
        end else if (reg_bus.addr == `CGC_OFS_STATUS) begin
            reg_bus.rdata[NUM_GEN-1:0] = gen_clk;
        end
    end

    // ************************************************************
    // Source inputs, with generator one fed back.
    // ************************************************************
    assign sources = {frac_phase_locked_loop_96_i,
                      freq_locked_loop_48_i,
                      internal_8mhz_osc_i,
                      crystal_32k_osc_i,
                      internal_32k_osc_i,
                      ultra_low_power_32k_osc_i,
                      gen_clk[1],
                      gen_input_pad_i,
                      crystal_osc_i};

    // ************************************************************
    // Generators.
    // ************************************************************
    for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
        always_comb begin
            cfg[g].source_level = 1'b0;
            // Reserved codes leave the source low.
            for (int s = 0; s < `CGC_NUM_SOURCES; s++) begin
                if (ctrl_q[g].source_select == 5'(s)) begin
                    cfg[g].source_level = sources[s];
                end
            end
        end
        assign cfg[g].gen_on  = ctrl_q[g].gen_on;
        assign cfg[g].balance = ctrl_q[g].duty_balance;
        assign cfg[g].mode    = ctrl_q[g].divide_mode;
        assign cfg[g].factor  = factor_q[g];

        cgc_gen_divider u_div (
            .clk_i     (clk_i),
            .resetn_i  (resetn_i),
            .cfg       (cfg[g].div),
            .gen_clk_o (gen_clk[g])
        );
    end

    assign gen_clk_o = gen_clk;

endmodule

// File: cgc_clock_generator_config_pad.sv
`timescale 1ns/10ps
// ****************************************************************
// No logic in this file.
// ****************************************************************

// File: cgc_osc_model.sv
`timescale 1ns/10ps

// ****************************************************************
// Free-running source clocks, each slower than half the bus clock.
// ****************************************************************
module cgc_osc_model (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    output logic      [7:0] src_o
);
    logic [15:0] cnt_q;
    logic [15:0] cnt_d;
    logic [7:0]  src_q;
    logic [7:0]  src_d;

    always_comb begin
        cnt_d = cnt_q + 16'h0001;
        src_d = src_q;
        for (int i = 0; i < 8; i++) begin
            if (cnt_q % 16'(i + 2) == 16'h0000) begin
                src_d[i] = ~src_q[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q <= 16'h0000;
            src_q <= 8'h00;
        end else begin
            cnt_q <= cnt_d;
            src_q <= src_d;
        end
    end

    assign src_o = src_q;
endmodule

// File: cgc_clock_generator_config_props.sv
`timescale 1ns/10ps

// ****************************************************************
// Port checks of the generator configuration block.
// ****************************************************************
module cgc_config_props
    import cgc_pkg::*;
#(
    parameter int NUM_GEN = 9
) (
    input wire logic               clk_i,
    input wire logic               resetn_i,
    input wire logic [4:0]         avs_address_i,
    input wire logic               avs_read_i,
    input wire logic               avs_write_i,
    input wire logic               avs_waitrequest_o,
    input wire logic [31:0]        avs_readdata_o,
    input wire logic [NUM_GEN-1:0] gen_clk_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic rd_done;
    assign rd_done = avs_read_i && !avs_waitrequest_o;

    AST_WAIT_ONE: assert property ((avs_read_i || avs_write_i) &&
        avs_waitrequest_o |=> !avs_waitrequest_o) else $error("late answer");
    AST_WAIT_SHORT: assert property (!avs_waitrequest_o |=>
        avs_waitrequest_o) else $error("answer too long");
    AST_IDLE_STALL: assert property (!(avs_read_i || avs_write_i)
        |=> avs_waitrequest_o) else $error("answer without request");
    AST_RST_OUT_LOW: assert property (resetn_i && !$past(resetn_i)
        |-> gen_clk_o == '0) else $error("output high at reset");
    AST_CTRL_ZERO: assert property (rd_done && avs_address_i == 5'h04
        |-> (avs_readdata_o & 32'hffc0e0f0) == 32'h0) else $error("ctrl bits");
    AST_DIV_ZERO: assert property (rd_done && avs_address_i == 5'h08
        |-> (avs_readdata_o & 32'hff0000f0) == 32'h0) else $error("div bits");
    AST_DIV_G2: assert property (rd_done && avs_address_i == 5'h08 &&
        avs_readdata_o[3:0] == 4'h2 |-> avs_readdata_o[23:13] == 11'h0)
        else $error("gen two factor too wide");
    AST_DIV_NARROW: assert property (rd_done && avs_address_i == 5'h08
        && avs_readdata_o[3:0] inside {4'h0, [4'h3:4'h8]}
        |-> avs_readdata_o[23:16] == 8'h0) else $error("factor too wide");
    AST_RD_HOLD: assert property (!(avs_read_i && avs_waitrequest_o)
        |=> $stable(avs_readdata_o)) else $error("read data moved");

    cover property (rd_done && avs_address_i == 5'h08);
    cover property (avs_write_i && !avs_waitrequest_o);
    cover property ($rose(gen_clk_o[4]));
endmodule

bind cgc_clock_generator_config cgc_config_props #(.NUM_GEN(NUM_GEN)) u_props (
    .clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_waitrequest_o(avs_waitrequest_o), .avs_readdata_o(avs_readdata_o),
    .gen_clk_o(gen_clk_o));

// File: cgc_clock_generator_config_test.sv
`timescale 1ns/10ps
`define CHECK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("Error at %0t: got %h exp %h", $time, (g), (e)); end end

// ****************************************************************
// Register and output tests of the generator configuration block.
// ****************************************************************
module cgc_clock_generator_config_test;
    logic        clk_i            = 1'b0;
    logic        resetn_i         = 1'b0;
    logic        user_reset_i     = 1'b0;
    logic [4:0]  avs_address_i    = 5'h00;
    logic        avs_read_i       = 1'b0;
    logic        avs_write_i      = 1'b0;
    logic [31:0] avs_writedata_i  = 32'h0;
    logic [3:0]  avs_byteenable_i = 4'h0;
    logic        avs_waitrequest_o;
    logic [31:0] avs_readdata_o;
    logic [7:0]  src;
    logic [8:0]  gen_clk_o;
    logic [31:0] rd;
    int          n_errors = 0;
    int          checked  = 0;
    int          fac[4]   = '{4, 2, 4, 3};
    logic [7:0]  flg[4]   = '{8'h01, 8'h11, 8'h00, 8'h03};
    int          ex[4]    = '{30, 15, 0, 40};

    always #10 clk_i = ~clk_i;

    cgc_osc_model u_osc (.clk_i(clk_i), .resetn_i(resetn_i), .src_o(src));

    cgc_clock_generator_config DUT (
        .clk_i(clk_i), .resetn_i(resetn_i), .user_reset_i(user_reset_i),
        .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
        .avs_byteenable_i(avs_byteenable_i),
        .avs_waitrequest_o(avs_waitrequest_o), .avs_readdata_o(avs_readdata_o),
        .crystal_osc_i(src[0]), .gen_input_pad_i(src[1]),
        .ultra_low_power_32k_osc_i(src[2]), .internal_32k_osc_i(src[3]),
        .crystal_32k_osc_i(src[4]), .internal_8mhz_osc_i(src[5]),
        .freq_locked_loop_48_i(src[6]), .frac_phase_locked_loop_96_i(src[7]),
        .gen_clk_o(gen_clk_o));

    task automatic acc(input logic wr, input logic [4:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0) @(posedge clk_i);
        rd = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic chk(input logic [4:0] a, input logic [3:0] g,
                       input logic [31:0] e);
        acc(1'b1, a, {28'h0, g}, 4'h1);
        acc(1'b0, a, 32'h0, 4'h0);
        `CHECK(rd, e)
    endtask

    function automatic logic [15:0] fmask(input int g);
        return (g == 1) ? 16'hffff : (g == 2) ? 16'h001f : 16'h00ff;
    endfunction

    function automatic logic [31:0] ctrl_rst(input int g);
        return (g == 0) ? 32'h00010600 : (g == 2) ? 32'h00010302 : 32'(g);
    endfunction

    task automatic meas(input int g, output int rises, output int highs);
        logic p;
        rises = 0;
        highs = 0;
        repeat (200) @(posedge clk_i);
        p = gen_clk_o[g];
        repeat (1680) begin
            @(posedge clk_i);
            rises += int'(gen_clk_o[g] && !p);
            highs += int'(gen_clk_o[g]);
            p = gen_clk_o[g];
        end
    endtask

    task tally_and_finish;
        $display("TB: errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        int r;
        int h;
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        for (int g = 0; g < 9; g++) begin
            chk(5'h04, 4'(g), ctrl_rst(g));
            chk(5'h08, 4'(g), 32'(g));
        end
        for (int s = 0; s < 9; s++) begin
            acc(1'b1, 5'h04, 32'h00030003 | 32'(s << 8), 4'h7);
            chk(5'h04, 4'h3, 32'h00030003 | 32'(s << 8));
        end
        chk(5'h04, 4'h4, 32'h4);
        acc(1'b1, 5'h04, 32'h00010709, 4'hf);
        chk(5'h04, 4'h9, 32'h9);
        chk(5'h04, 4'h8, 32'h8);
        for (int g = 0; g < 9; g++) begin
            acc(1'b1, 5'h08, 32'h00ffff00 | 32'(g), 4'hf);
            chk(5'h08, 4'(g), {8'h0, fmask(g), 4'h0, 4'(g)});
        end
        acc(1'b0, 5'h14, 32'h0, 4'h0);
        `CHECK(rd, 32'h0)
        acc(1'b1, 5'h0c, 32'h4, 4'hf);
        acc(1'b1, 5'h04, 32'h00000700, 4'h7);
        acc(1'b1, 5'h04, 32'h00000402, 4'h7);
        user_reset_i <= 1'b1;
        @(posedge clk_i);
        user_reset_i <= 1'b0;
        @(posedge clk_i);
        chk(5'h04, 4'h0, 32'h00010600);
        chk(5'h04, 4'h2, 32'h00000402);
        chk(5'h04, 4'h3, 32'h3);
        chk(5'h08, 4'h3, 32'h3);
        chk(5'h08, 4'h2, 32'h00001f02);
        for (int k = 0; k < 4; k++) begin
            acc(1'b1, 5'h08, {16'h0, 8'(fac[k]), 8'h04}, 4'hf);
            acc(1'b1, 5'h04, {8'h0, flg[k], 8'h06, 8'h04}, 4'h7);
            meas(4, r, h);
            `CHECK(r >= ex[k] - 1 && r <= ex[k] + 1, 1'b1)
            if (k == 2) begin
                acc(1'b0, 5'h10, 32'h0, 4'h0);
                `CHECK(rd[4], 1'b0)
            end
        end
        `CHECK(h >= 819 && h <= 861, 1'b1)
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        tally_and_finish();
    end
endmodule
